/* verilog/cptp_top.sv */
`timescale 1ns/1ns
// Overview of operation
// R1 - Send once per period, 0..65535 ms, default 1000; zero period sends nothing.
// R2 - Channels reset disabled and stay silent until software enables them.
// R3 - Frame length is the configured 1..8 bytes, default 8.
// R4 - Three-bit priority 0..7 goes in the identifier, default 6.
// R5 - PDU1 groups carry an 8-bit destination, default 254.
// R6 - Each signal type enables or disables it; default continuous, code 2.
// R7 - Size codes 0 off, 1/2/4 bits, 1/2/4 bytes; default code 5.
// R8 - Signal LSB byte sits at index 0..7; signal one defaults to 0.
// R9 - Signal two defaults to byte index 2.
// R10 - Bit index 0..7 places the LSB only for sub-byte sizes.
// R11 - Each signal has its own resolution and offset, defaults 0.001 and 0.
// R12 - Each signal picks source and instance; defaults AC input, 1, 2.
// R13 - Channels sharing a PGN run at the lowest enabled channel's period.
// R14 - Signal four defaults to two bytes at byte index 6.
// R15 - Value is (source - offset) / resolution, LSB first, saturated to field.
// R16 - A 16-bit PGN is carried in each frame identifier; PDU1 frames carry the destination in place of its low byte.
module cptp_top #(
	parameter int unsigned MS_CYCLES = cptp_pkg::MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic src_req_o,
	output logic [3:0] src_kind_o,
	output logic [3:0] src_inst_o,
	input wire logic src_ack_i,
	input wire logic [31:0] src_val_i,
	output logic tx_req_o,
	output logic [28:0] tx_id_o,
	output logic [3:0] tx_dlc_o,
	output logic [63:0] tx_data_o,
	input wire logic tx_ack_i
);
	localparam int NC = cptp_pkg::NUM_CH;
	localparam int NS = cptp_pkg::NUM_SIG;
	localparam int NSL = cptp_pkg::NUM_SLOT;
	localparam int CW = $clog2(NC);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] clamp_len(input logic [31:0] v);
		if (v < 32'(cptp_pkg::LEN_MIN)) begin
			return cptp_pkg::LEN_MIN;
		end else if (v > 32'(cptp_pkg::LEN_MAX)) begin
			return cptp_pkg::LEN_MAX;
		end
		return v[3:0];
	endfunction

	function automatic logic [63:0] put_field(input logic [63:0] d, input logic [31:0] v,
		input logic [63:0] wm, input logic [5:0] pos);
		logic [63:0] m;
		m = wm << pos;
		return (d & ~m) | (({32'h0, v} << pos) & m);
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [NC-1:0] en_q;
	logic [NC-1:0] pend_q;
	logic [15:0] pgn_q [NC];
	logic [15:0] per_q [NC];
	logic [7:0] dest_q [NC];
	logic [3:0] len_q [NC];
	logic [2:0] prio_q [NC];
	logic [15:0] sent_q [NC];
	logic [15:0] cnt_q [NC];
	logic [15:0] eff [NC];
	logic [NC-1:0] fire;
	logic [3:0] typ_q [NSL];
	logic [2:0] size_q [NSL];
	logic [2:0] byte_q [NSL];
	logic [2:0] bit_q [NSL];
	logic [3:0] src_q [NSL];
	logic [3:0] num_q [NSL];
	logic [31:0] res_q [NSL];
	logic [31:0] ofs_q [NSL];
	logic [7:0] sa_q;
	logic [31:0] pre_q;
	logic ms_tick_q;
	cptp_pkg::cptp_state_e st_q;
	logic [CW-1:0] cur_q;
	logic [CW-1:0] pick;
	logic [2:0] slot_q;
	logic [63:0] data_q;
	logic neg_q;
	logic div_go_q;
	logic [32:0] dvd_q;
	logic [31:0] dvs_q;
	logic [32:0] quo;
	logic div_done;
	logic tx_done;

	// ---------------------------------------------------------------
	// Wishbone decode
	// ---------------------------------------------------------------
	logic bus_req, rd_hit, wr_en, glob, sig_hit, ch_a;
	logic [7:0] lo;
	logic [2:0] si_a;
	logic [31:0] rdv, wval;

	always_comb begin
		bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		glob = wb_adr_i[9];
		ch_a = wb_adr_i[8];
		lo = wb_adr_i[7:0];
		sig_hit = !glob && lo[7:6] == cptp_pkg::SIG_REGION;
		si_a = {ch_a, lo[5:4]};
		rdv = '0;
		rd_hit = 1'b1;
		if (glob) begin
			if (lo == cptp_pkg::OFF_SA) begin
				rdv[7:0] = sa_q;
			end else begin
				rd_hit = 1'b0;
			end
		end else if (sig_hit) begin
			case (lo[3:2])
				cptp_pkg::FLD_CFG: begin
					rdv[cptp_pkg::CFG_TYPE +: 4] = typ_q[si_a];
					rdv[cptp_pkg::CFG_SIZE +: 3] = size_q[si_a];
					rdv[cptp_pkg::CFG_BYTE +: 3] = byte_q[si_a];
					rdv[cptp_pkg::CFG_BIT +: 3] = bit_q[si_a];
					rdv[cptp_pkg::CFG_SRC +: 4] = src_q[si_a];
					rdv[cptp_pkg::CFG_NUM +: 4] = num_q[si_a];
				end
				cptp_pkg::FLD_RES: rdv = res_q[si_a];
				cptp_pkg::FLD_OFS: rdv = ofs_q[si_a];
				default: rd_hit = 1'b0;
			endcase
		end else begin
			case (lo)
				cptp_pkg::OFF_CTRL: rdv[0] = en_q[ch_a];
				cptp_pkg::OFF_PGN: rdv[15:0] = pgn_q[ch_a];
				cptp_pkg::OFF_PER: rdv[15:0] = per_q[ch_a];
				cptp_pkg::OFF_DEST: rdv[7:0] = dest_q[ch_a];
				cptp_pkg::OFF_LEN: rdv[3:0] = len_q[ch_a];
				cptp_pkg::OFF_PRIO: rdv[2:0] = prio_q[ch_a];
				cptp_pkg::OFF_STAT: begin
					rdv[cptp_pkg::STAT_PEND] = pend_q[ch_a];
					rdv[cptp_pkg::STAT_BUSY] = st_q != cptp_pkg::ST_IDLE && cur_q == ch_a;
					rdv[cptp_pkg::STAT_SENT +: 16] = sent_q[ch_a];
				end
				default: rd_hit = 1'b0;
			endcase
		end
		wr_en = bus_req && wb_we_i && rd_hit;
		wval = merge(rdv, wb_dat_i, wb_sel_i);
	end

	// One wait state: ack and read data both come from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req && !wb_we_i ? rdv : '0;
		end
	end

	// ---------------------------------------------------------------
	// Channel settings
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NC; c++) begin
				en_q[c] <= 1'b0; // R2
				pgn_q[c] <= cptp_pkg::DEF_PGN + 16'(c); // R16
				per_q[c] <= cptp_pkg::DEF_PER; // R1
				dest_q[c] <= cptp_pkg::DEF_DEST; // R5
				len_q[c] <= cptp_pkg::LEN_MAX; // R3
				prio_q[c] <= cptp_pkg::DEF_PRIO; // R4
			end
			sa_q <= cptp_pkg::DEF_SA;
		end else if (wr_en && glob) begin
			sa_q <= wval[7:0];
		end else if (wr_en && !sig_hit) begin
			case (lo)
				cptp_pkg::OFF_CTRL: en_q[ch_a] <= wval[0];
				cptp_pkg::OFF_PGN: pgn_q[ch_a] <= wval[15:0];
				cptp_pkg::OFF_PER: per_q[ch_a] <= wval[15:0];
				cptp_pkg::OFF_DEST: dest_q[ch_a] <= wval[7:0];
				cptp_pkg::OFF_LEN: len_q[ch_a] <= clamp_len(wval); // R3
				cptp_pkg::OFF_PRIO: prio_q[ch_a] <= wval[2:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Signal slot settings
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NSL; i++) begin
				typ_q[i] <= cptp_pkg::TYPE_CONT; // R6
				size_q[i] <= cptp_pkg::SZ_2BYTE; // R7
				byte_q[i] <= cptp_pkg::def_byte(i % NS); // R8 R9 R14
				bit_q[i] <= '0;
				src_q[i] <= cptp_pkg::SRC_AC; // R12
				num_q[i] <= 4'((i % NS) + 1); // R12
				res_q[i] <= cptp_pkg::DEF_RES; // R11
				ofs_q[i] <= cptp_pkg::DEF_OFS; // R11
			end
		end else if (wr_en && sig_hit) begin
			case (lo[3:2])
				cptp_pkg::FLD_CFG: begin
					typ_q[si_a] <= wval[cptp_pkg::CFG_TYPE +: 4];
					size_q[si_a] <= wval[cptp_pkg::CFG_SIZE +: 3];
					byte_q[si_a] <= wval[cptp_pkg::CFG_BYTE +: 3];
					bit_q[si_a] <= wval[cptp_pkg::CFG_BIT +: 3];
					src_q[si_a] <= wval[cptp_pkg::CFG_SRC +: 4];
					num_q[si_a] <= wval[cptp_pkg::CFG_NUM +: 4];
				end
				cptp_pkg::FLD_RES: res_q[si_a] <= wval;
				cptp_pkg::FLD_OFS: ofs_q[si_a] <= wval;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Millisecond timebase and repetition timers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_q <= '0;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= pre_q == MS_CYCLES - 1;
			pre_q <= pre_q == MS_CYCLES - 1 ? '0 : pre_q + 32'h1;
		end
	end

	// A higher channel on a lower enabled channel's PGN borrows that period
	always_comb begin
		logic found;
		found = 1'b0;
		for (int c = 0; c < NC; c++) begin
			eff[c] = per_q[c];
			found = 1'b0;
			for (int j = 0; j < NC; j++) begin
				if (!found && j < c && en_q[j] && pgn_q[j] == pgn_q[c]) begin
					eff[c] = per_q[j]; // R13
					found = 1'b1;
				end
			end
			fire[c] = en_q[c] && eff[c] != 16'h0 && ms_tick_q &&
				{1'b0, cnt_q[c]} + 17'h1 >= {1'b0, eff[c]}; // R1 R2
		end
		pick = '0;
		for (int c = NC - 1; c >= 0; c--) begin
			if (pend_q[c]) begin
				pick = CW'(c);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NC; c++) begin
				cnt_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (!en_q[c] || eff[c] == 16'h0 || fire[c]) begin
					cnt_q[c] <= '0;
				end else if (ms_tick_q) begin
					cnt_q[c] <= cnt_q[c] + 16'h1;
				end
			end
		end
	end

	// A new expiry in the cycle the frame completes keeps the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= '0;
		end else begin
			for (int c = 0; c < NC; c++) begin
				pend_q[c] <= fire[c] || (pend_q[c] && en_q[c] && eff[c] != 16'h0 &&
					!(tx_done && cur_q == CW'(c))); // R1 R13
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NC; c++) begin
				sent_q[c] <= '0;
			end
		end else if (tx_done) begin
			sent_q[cur_q] <= sent_q[cur_q] + 16'h1;
		end
	end

	// ---------------------------------------------------------------
	// Scaling, packing and identifier
	// ---------------------------------------------------------------
	logic [2:0] si_c;
	logic sig_on;
	logic [32:0] diff, maxv, sat;
	logic [31:0] res_c;
	logic [5:0] w, pos;
	logic [63:0] wmask;
	logic [7:0] pf, ps;
	logic [28:0] frame_id;

	always_comb begin
		si_c = {cur_q, slot_q[1:0]};
		res_c = res_q[si_c];
		sig_on = typ_q[si_c] != cptp_pkg::TYPE_OFF &&
			size_q[si_c] != cptp_pkg::SZ_OFF; // R6 R7
		diff = {src_val_i[31], src_val_i} - {ofs_q[si_c][31], ofs_q[si_c]}; // R15
		w = cptp_pkg::width_of(size_q[si_c]); // R7
		maxv = (33'h1 << w) - 33'h1;
		wmask = (64'h1 << w) - 64'h1;
		// Negative results clip to zero; the field is unsigned
		sat = neg_q && quo != 33'h0 ? 33'h0 : (quo > maxv ? maxv : quo); // R15
		pos = {byte_q[si_c], 3'h0} +
			(w < cptp_pkg::BYTE_BITS ? {3'h0, bit_q[si_c]} : 6'h00); // R8 R10
		pf = pgn_q[cur_q][15:8];
		ps = pf < cptp_pkg::PDU2_PF ? dest_q[cur_q] : pgn_q[cur_q][7:0]; // R5 R16
		frame_id = {prio_q[cur_q], cptp_pkg::ID_RDP, pf, ps, sa_q}; // R4
		tx_done = tx_req_o && tx_ack_i;
	end

	cptp_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(div_go_q),
		.dvd_i(dvd_q),
		.dvs_i(dvs_q),
		.quo_o(quo),
		.done_o(div_done)
	);

	// ---------------------------------------------------------------
	// Frame builder
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= cptp_pkg::ST_IDLE;
			cur_q <= '0;
			slot_q <= '0;
			data_q <= '0;
			neg_q <= 1'b0;
			div_go_q <= 1'b0;
			dvd_q <= '0;
			dvs_q <= '0;
			src_req_o <= 1'b0;
			src_kind_o <= '0;
			src_inst_o <= '0;
			tx_req_o <= 1'b0;
			tx_id_o <= '0;
			tx_dlc_o <= '0;
			tx_data_o <= '0;
		end else begin
			div_go_q <= 1'b0;
			if (tx_done) begin
				tx_req_o <= 1'b0;
			end
			unique case (st_q)
				cptp_pkg::ST_IDLE: begin
					if (|pend_q && !tx_req_o) begin
						cur_q <= pick;
						slot_q <= '0;
						data_q <= {8{cptp_pkg::FILL_BYTE}};
						st_q <= cptp_pkg::ST_SLOT;
					end
				end
				cptp_pkg::ST_SLOT: begin
					if (slot_q == 3'(NS)) begin
						tx_req_o <= 1'b1;
						tx_id_o <= frame_id; // R4 R5 R16
						tx_dlc_o <= len_q[cur_q]; // R3
						tx_data_o <= data_q;
						st_q <= cptp_pkg::ST_IDLE;
					end else if (sig_on) begin
						src_req_o <= 1'b1;
						src_kind_o <= src_q[si_c]; // R12
						src_inst_o <= num_q[si_c]; // R12
						st_q <= cptp_pkg::ST_FETCH;
					end else begin
						slot_q <= slot_q + 3'h1; // R6
					end
				end
				cptp_pkg::ST_FETCH: begin
					if (src_ack_i) begin
						src_req_o <= 1'b0;
						neg_q <= diff[32] ^ res_c[31]; // R11 R15
						dvd_q <= diff[32] ? 33'h0 - diff : diff;
						dvs_q <= res_c[31] ? 32'h0 - res_c : res_c;
						div_go_q <= 1'b1;
						st_q <= cptp_pkg::ST_DIV;
					end
				end
				cptp_pkg::ST_DIV: begin
					if (div_done) begin
						st_q <= cptp_pkg::ST_PACK;
					end
				end
				cptp_pkg::ST_PACK: begin
					data_q <= put_field(data_q, sat[31:0], wmask, pos); // R8 R10 R15
					slot_q <= slot_q + 3'h1;
					st_q <= cptp_pkg::ST_SLOT;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_bus_give;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_tx_wait;
		tx_req_o && !tx_ack_i;
	endsequence

	chk_bus_ack_once: assert property (s_bus_take |=> s_bus_give)
		else $error("bus ack not a single pulse one cycle after request");
	chk_tx_hold_frame: assert property (s_tx_wait |=>
		tx_req_o && $stable(tx_data_o) && $stable(tx_id_o)) // R3
		else $error("frame changed before controller took it");
	chk_enable_gate: assert property ($rose(pend_q[0]) |-> $past(en_q[0])) // R2
		else $error("disabled channel requested a frame");
	chk_zero_period: assert property ($rose(pend_q[0]) |-> $past(eff[0]) != 16'h0) // R1
		else $error("frame requested with zero period");
	chk_shared_rate: assert property ($rose(pend_q[1]) |-> // R13
		!($past(en_q[0]) && $past(pgn_q[0]) == $past(pgn_q[1]) && $past(per_q[0]) == 16'h0))
		else $error("shared PGN sent despite zero lowest period");
	chk_dlc_range: assert property ($rose(tx_req_o) |-> // R3
		tx_dlc_o == $past(len_q[cur_q]) && tx_dlc_o >= cptp_pkg::LEN_MIN &&
		tx_dlc_o <= cptp_pkg::LEN_MAX)
		else $error("frame length out of range");
	chk_prio_field: assert property ($rose(tx_req_o) |-> // R4
		tx_id_o[cptp_pkg::ID_PRIO_LSB +: 3] == $past(prio_q[cur_q]))
		else $error("priority missing from identifier");
	chk_pdu1_dest: assert property ($rose(tx_req_o) && // R5
		tx_id_o[cptp_pkg::ID_PF_LSB +: 8] < cptp_pkg::PDU2_PF |->
		tx_id_o[cptp_pkg::ID_PS_LSB +: 8] == $past(dest_q[cur_q]))
		else $error("PDU1 destination wrong");
	chk_pgn_field: assert property ($rose(tx_req_o) |-> // R16
		tx_id_o[cptp_pkg::ID_PF_LSB +: 8] == $past(pgn_q[cur_q][15:8]))
		else $error("PGN format byte wrong");
	chk_src_select: assert property ($rose(src_req_o) |-> // R12
		src_kind_o == $past(src_q[si_c]) && src_inst_o == $past(num_q[si_c]) &&
		$past(typ_q[si_c]) != cptp_pkg::TYPE_OFF) // R6
		else $error("wrong source fetched or disabled signal fetched");
	chk_sat_range: assert property (st_q == cptp_pkg::ST_PACK |-> // R15
		sat <= maxv && (!neg_q || sat == 33'h0))
		else $error("field value not saturated");
	chk_field_place: assert property (st_q == cptp_pkg::ST_PACK && // R8 R10
		{1'b0, pos} + {1'b0, w} <= 7'h40 |=>
		((data_q >> $past(pos)) & $past(wmask)) == ({31'h0, $past(sat)} & $past(wmask)))
		else $error("field not placed at its bit position");
	chk_reset_layout: assert property ($fell(rst_i) |-> // R9 R14
		byte_q[1] == cptp_pkg::def_byte(1) && byte_q[3] == cptp_pkg::def_byte(3))
		else $error("default byte layout wrong");
endmodule

/* shared/cptp_pkg.sv */
package cptp_pkg;
	// -------------------------------------------------------------
	// Sizes and timing
	// -------------------------------------------------------------
	localparam int NUM_CH = 2;
	localparam int NUM_SIG = 4;
	localparam int NUM_SLOT = NUM_CH * NUM_SIG;
	localparam int CLK_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int DIV_STEPS = 33;
	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PGN = 8'h04;
	localparam logic [7:0] OFF_PER = 8'h08;
	localparam logic [7:0] OFF_DEST = 8'h0c;
	localparam logic [7:0] OFF_LEN = 8'h10;
	localparam logic [7:0] OFF_PRIO = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_SA = 8'h00;
	localparam logic [1:0] SIG_REGION = 2'h1;
	localparam logic [1:0] FLD_CFG = 2'h0;
	localparam logic [1:0] FLD_RES = 2'h1;
	localparam logic [1:0] FLD_OFS = 2'h2;
	localparam int CFG_TYPE = 0;
	localparam int CFG_SIZE = 4;
	localparam int CFG_BYTE = 8;
	localparam int CFG_BIT = 12;
	localparam int CFG_SRC = 16;
	localparam int CFG_NUM = 24;
	localparam int STAT_PEND = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_SENT = 16;
	// -------------------------------------------------------------
	// Reset values and encodings
	// -------------------------------------------------------------
	localparam logic [15:0] DEF_PGN = 16'hff00;
	localparam logic [15:0] DEF_PER = 16'h03e8;
	localparam logic [7:0] DEF_DEST = 8'hfe;
	localparam logic [3:0] LEN_MIN = 4'h1;
	localparam logic [3:0] LEN_MAX = 4'h8;
	localparam logic [2:0] DEF_PRIO = 3'h6;
	localparam logic [3:0] TYPE_OFF = 4'h0;
	localparam logic [3:0] TYPE_CONT = 4'h2;
	localparam logic [2:0] SZ_OFF = 3'h0;
	localparam logic [2:0] SZ_2BYTE = 3'h5;
	localparam logic [3:0] SRC_AC = 4'h1;
	localparam logic [31:0] DEF_RES = 32'h00000001;
	localparam logic [31:0] DEF_OFS = 32'h00000000;
	localparam int BYTE_STEP = 2;
	localparam logic [7:0] DEF_SA = 8'h80;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [7:0] PDU2_PF = 8'hf0;
	localparam logic [1:0] ID_RDP = 2'h0;
	localparam int ID_PRIO_LSB = 26;
	localparam int ID_PF_LSB = 16;
	localparam int ID_PS_LSB = 8;
	localparam logic [5:0] BYTE_BITS = 6'h08;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SLOT = 5'h02,
		ST_FETCH = 5'h04,
		ST_DIV = 5'h08,
		ST_PACK = 5'h10
	} cptp_state_e;

	function automatic logic [5:0] width_of(input logic [2:0] code);
		case (code)
			3'h1: return 6'h01;
			3'h2: return 6'h02;
			3'h3: return 6'h04;
			3'h4: return 6'h08;
			3'h5: return 6'h10;
			3'h6: return 6'h20;
			default: return 6'h00;
		endcase
	endfunction

	function automatic logic [2:0] def_byte(input int s);
		return 3'(s * BYTE_STEP);
	endfunction
endpackage

/* verilog/cptp_div.sv */
`timescale 1ns/1ns
// Restoring unsigned divider, one quotient bit per clock.
// A zero divisor gives an all-ones quotient, which the caller saturates.
module cptp_div (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [32:0] dvd_i,
	input wire logic [31:0] dvs_i,
	output logic [32:0] quo_o,
	output logic done_o
);
	logic [32:0] rem_q;
	logic [31:0] dvs_q;
	logic [5:0] cnt_q;
	logic [32:0] trial;

	always_comb begin
		trial = {rem_q[31:0], quo_o[32]};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rem_q <= '0;
			dvs_q <= '0;
			quo_o <= '0;
			cnt_q <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				rem_q <= '0;
				quo_o <= dvd_i;
				dvs_q <= dvs_i;
				cnt_q <= 6'(cptp_pkg::DIV_STEPS);
			end else if (cnt_q != 6'h00) begin
				if (trial >= {1'b0, dvs_q}) begin
					rem_q <= trial - {1'b0, dvs_q};
					quo_o <= {quo_o[31:0], 1'b1};
				end else begin
					rem_q <= trial;
					quo_o <= {quo_o[31:0], 1'b0};
				end
				cnt_q <= cnt_q - 6'h01;
				done_o <= cnt_q == 6'h01;
			end
		end
	end
endmodule

/* tb/cptp_far_end.sv */
`timescale 1ns/1ns
// Signal sources plus CAN controller; slow_i stretches both answers.
module cptp_far_end (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic src_req_i,
	input wire logic [3:0] src_kind_i,
	input wire logic [3:0] src_inst_i,
	output logic src_ack_o,
	output logic [31:0] src_val_o,
	input wire logic tx_req_i,
	output logic tx_ack_o,
	input wire logic [31:0] base_i,
	input wire logic slow_i
);
	logic [2:0] src_cnt_q;
	logic [2:0] tx_cnt_q;
	logic [2:0] lim;
	assign lim = slow_i ? 3'h6 : 3'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i || src_ack_o) begin
			src_ack_o <= 1'b0;
			src_cnt_q <= 3'h0;
		end else if (src_req_i) begin
			src_ack_o <= (src_cnt_q == lim);
			src_cnt_q <= src_cnt_q + 3'h1;
		end
	end
	// Value only holds in the ack cycle; it toggles otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i)
			src_val_o <= 32'h5a5a5a5a;
		else if (src_req_i && !src_ack_o && src_cnt_q == lim)
			src_val_o <= (src_kind_i == 4'h1) ? base_i + 32'(src_inst_i) * 32'h3e8 : 32'h0;
		else
			src_val_o <= ~src_val_o;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || tx_ack_o) begin
			tx_ack_o <= 1'b0;
			tx_cnt_q <= 3'h0;
		end else if (tx_req_i) begin
			tx_ack_o <= (tx_cnt_q == lim);
			tx_cnt_q <= tx_cnt_q + 3'h1;
		end
	end
endmodule

/* tb/test_can_periodic_transmit_packer.sv */
`timescale 1ns/1ns
module test_can_periodic_transmit_packer;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, src_ack_i, tx_ack_i, src_req_o;
	logic wb_ack_o, tx_req_o, slow;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i, src_kind_o, src_inst_o, tx_dlc_o;
	logic [31:0] wb_dat_i, wb_dat_o, src_val_i, rd, base;
	logic [28:0] tx_id_o;
	logic [63:0] tx_data_o, d;
	logic [7:0] dest;
	logic [2:0] prio;
	int n_mismatch = 0, n_compared = 0, cycles = 0, seed, k, sz, pos, res, ofs, len;
	time t_req = 0, t_gap = 0;
	int wtab[7] = '{0, 1, 2, 4, 8, 16, 32};

	cptp_top #(.MS_CYCLES(10)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_req_o, .src_kind_o,
		.src_inst_o, .src_ack_i, .src_val_i, .tx_req_o, .tx_id_o, .tx_dlc_o, .tx_data_o,
		.tx_ack_i);
	cptp_far_end far (.clk_i, .rst_i, .src_req_i(src_req_o), .src_kind_i(src_kind_o),
		.src_inst_i(src_inst_o), .src_ack_o(src_ack_i), .src_val_o(src_val_i),
		.tx_req_i(tx_req_o), .tx_ack_o(tx_ack_i), .base_i(base), .slow_i(slow));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task end_sim;
		$display("Mismatches %0d, compares %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [9:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= v;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, {32'h0, rd}, {32'h0, e});
	endtask
	// Expected field: (src - ofs) / res, clamped to 0..max, clipped past bit 63
	function logic [63:0] put(input logic [63:0] f, input longint s, input longint o,
		input longint r, input int w, input int p);
		longint v, m;
		m = (longint'(1) << w) - 1;
		v = s - o;
		v = (v < 0) ? 0 : (r == 0) ? m : v / r;
		if (v > m)
			v = m;
		for (int i = 0; i < w; i++)
			if (p + i < 64)
				f[p + i] = v[i];
		return f;
	endfunction
	task frame(input logic [28:0] eid, input logic [3:0] edlc, input logic [63:0] edat);
		do @(posedge clk_i); while (tx_req_o !== 1'b1);
		t_gap = $time - t_req;
		t_req = $time;
		chk("tx_id", {35'h0, tx_id_o}, {35'h0, eid});
		chk("tx_dlc", {60'h0, tx_dlc_o}, {60'h0, edlc});
		chk("tx_data", tx_data_o, edat);
		do @(posedge clk_i); while (tx_req_o !== 1'b0);
	endtask
	task quiet(input string nm);
		k = 0;
		repeat (300) @(posedge clk_i) k += (tx_req_o !== 1'b0);
		chk(nm, 64'(k), 64'h0);
	endtask

	initial begin
		seed = 32'h07362ca6;
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, slow} = 5'h10;
		{wb_adr_i, wb_sel_i, wb_dat_i, base} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_sel_i <= 4'hf;
		rchk("period", 10'h008, 32'h3e8);
		rchk("dest", 10'h00c, 32'hfe);
		rchk("length", 10'h010, 32'h8);
		rchk("prio", 10'h014, 32'h6);
		rchk("pgn", 10'h104, 32'hff01);
		rchk("enable", 10'h000, 32'h0);
		rchk("res", 10'h044, 32'h1);
		rchk("unmapped", 10'h3fc, 32'h0);
		for (int s = 0; s < 4; s++)
			rchk("cfg", 10'(64 + s * 16),
				32'h00010052 | (s + 1) << 24 | (2 * s) << 8);
		quiet("idle");
		base = {$random(seed)} % 32'h20000;
		d = '1;
		for (int s = 0; s < 4; s++)
			d = put(d, base + (s + 1) * 1000, 0, 1, 16, 16 * s);
		wb(1'b1, 10'h008, 32'h14);
		wb(1'b1, 10'h000, 32'h1);
		frame({3'h6, 2'h0, 8'hff, 8'h00, 8'h80}, 4'h8, d);
		// Same build time for both frames, so the gap is the 20 ms period exactly
		frame({3'h6, 2'h0, 8'hff, 8'h00, 8'h80}, 4'h8, d);
		chk("period", 64'(t_gap), 64'hfa0);
		rchk("sent", 10'h018, 32'h00020000);
		wb(1'b1, 10'h000, 32'h0);
		dest = 8'($random(seed));
		prio = 3'($random(seed));
		wb(1'b1, 10'h004, 32'hea00);
		wb(1'b1, 10'h00c, 32'(dest));
		wb(1'b1, 10'h014, 32'(prio));
		wb(1'b1, 10'h000, 32'h1);
		frame({prio, 2'h0, 8'hea, dest, 8'h80}, 4'h8, d);
		wb(1'b1, 10'h000, 32'h0);
		for (int s = 1; s < 4; s++)
			wb(1'b1, 10'(64 + s * 16), 32'h0);
		for (int i = 0; i < 10; i++) begin
			sz = (i < 7) ? i : {$random(seed)} % 7;
			pos = {$random(seed)} % 64;
			len = 1 + {$random(seed)} % 8;
			res = (i == 8) ? 0 : 1 + {$random(seed)} % 2000;
			ofs = {$random(seed)} % 2001 - 1000;
			base = {$random(seed)} % 200000 - 50000;
			slow = $random(seed);
			wb(1'b1, 10'h040, 32'h01010002 | sz << 4 | (pos / 8) << 8 | (pos & 7) << 12);
			wb(1'b1, 10'h044, res);
			wb(1'b1, 10'h048, ofs);
			wb(1'b1, 10'h010, len);
			wb(1'b1, 10'h000, 32'h1);
			pos = (pos / 8) * 8 + ((sz >= 1 && sz <= 3) ? pos % 8 : 0);
			d = put('1, $signed(base) + 1000, ofs, res, wtab[sz], pos);
			frame({prio, 2'h0, 8'hea, dest, 8'h80}, 4'(len), d);
			wb(1'b1, 10'h000, 32'h0);
		end
		wb(1'b1, 10'h008, 32'h0);
		wb(1'b1, 10'h104, 32'hea00);
		wb(1'b1, 10'h108, 32'h1);
		// Lower channel first, else the higher one may fire alone on its own period
		wb(1'b1, 10'h000, 32'h1);
		wb(1'b1, 10'h100, 32'h1);
		quiet("shared_pgn");
		end_sim();
	end
endmodule
